// File: rtl/stepper_supervisor_spi_slave.sv
// Fault supervision, watchdog, sleep and serial register port of a stepper driver
//
// Contract
// [RULE1] Back-EMF output is the coil sample divided by two or four.
// [RULE2] Thermal warning flag sets while the warning comparator is active.
// [RULE3] Overheat shutdown sets its flag and disables every driver.
// [RULE4] Shutdown flag clears only after a status read with temperature below warning.
// [RULE5] Each over-current latches its own flag and disables drivers until cleared.
// [RULE6] Full duty beyond open-coil time disables that coil and sets its flag.
// [RULE7] Pump fault flag is one while pump is low, including start-up.
// [RULE8] Active-low fault output asserts whenever any fault flag is set.
// [RULE9] Host reset pin is held low for a while after power-up.
// [RULE10] Once armed, each kick write restarts the watchdog timer.
// [RULE11] Early or late kick pulses the host reset and sets boot flag.
// [RULE12] Watchdog reset reaches the pin after half a microsecond delay.
// [RULE13] Watchdog timeout is 32 ms times period code plus one.
// [RULE14] Hard reset input clears digital registers; pump keeps running.
// [RULE15] Sleep tri-states drivers, keeps registers, ignores steps, serves the port.
// [RULE16] Writing sleep zero wakes; host waits pump start-up before stepping.
// [RULE17] The port is slave only and never starts a transfer.
// [RULE18] Mode 0: shift out on falling, sample on rising clock edge.
// [RULE19] Chip select is active low; serial output released when unselected.
// [RULE20] Eighth falling clock loads the output shifter from the addressed register.
// [RULE21] Registers and status update only on clocks with chip select high; the boot flag sets on a watchdog fire even with chip select low.
// [RULE22] MSB first; byte one is command and address, byte two data.
// [RULE23] Gain is one half with gain bit zero, one quarter with one.
// [RULE24] Command bit seven selects write when one, read when zero; five-bit address.
// [RULE25] Write packets of other than sixteen bits are discarded.
// [RULE26] Reading a status register clears its latched flags; the boot flag clears instead on a watchdog write with kick bit zero.
// [RULE27] Pump start-up and open-coil durations are parameterised cycle counters.
`timescale 1ns/1ns
`include "stepper_supervisor_map.svh"
module stepper_supervisor_spi_slave #(
  parameter int OPEN_COIL_CYC = `OPEN_COIL_MS * (`CLK_HZ / 1000),
  parameter int WD_STEP_CYC = `WD_STEP_MS * (`CLK_HZ / 1000),
  parameter int WD_MIN_CYC = `WD_MIN_MS * (`CLK_HZ / 1000),
  parameter int WD_PULSE_CYC = `WD_PULSE_MS * (`CLK_HZ / 1000),
  parameter int POR_HOLD_CYC = `POR_HOLD_MS * (`CLK_HZ / 1000),
  parameter int PUMP_START_CYC = `PUMP_START_MS * (`CLK_HZ / 1000)
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  input wire logic temp_warning_in,
  input wire logic temp_shutdown_in,
  input wire logic [3:0] x_overcurrent_in,
  input wire logic [3:0] y_overcurrent_in,
  input wire logic [1:0] full_duty_in,
  input wire logic pump_low_in,
  input wire logic hard_reset_input,
  input wire logic step_advance_input,
  input wire stepper_supervisor_pkg::byte_t coil_voltage_sample,
  output stepper_supervisor_pkg::byte_t back_emf_output,
  output logic [3:0] x_bridge_enable,
  output logic [3:0] y_bridge_enable,
  output logic step_pulse,
  output logic fault_output_n,
  output logic host_reset_output_n,
  output logic host_reset_oe_n
);
  import stepper_supervisor_pkg::*;

  localparam int WD_DELAY_CYC = `WD_DELAY_NS * (`CLK_HZ / 1000000) / 1000;
  localparam int PIN_N = 15;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [PIN_N-1:0] pin_s1_r;
  logic [PIN_N-1:0] pin_s2_r;
  logic step_d_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {temp_warning_in, temp_shutdown_in, x_overcurrent_in, y_overcurrent_in,
        full_duty_in, pump_low_in, hard_reset_input, step_advance_input};
      pin_s2_r <= pin_s1_r;
    end
  end

  wire warn_s = pin_s2_r[14];
  wire shut_s = pin_s2_r[13];
  wire [3:0] ovcx_s = pin_s2_r[12:9];
  wire [3:0] ovcy_s = pin_s2_r[8:5];
  wire [1:0] full_s = pin_s2_r[4:3];
  wire pump_low_s = pin_s2_r[2];
  wire clr_s = pin_s2_r[1];
  wire step_s = pin_s2_r[0];

  // ------------------------------------------------------------
  // Serial port and command tracking
  // ------------------------------------------------------------
  spi_link_if link ();

  spi_shifter u_shifter (
    .clk(clk),
    .reset_n(reset_n),
    .sclk(sclk),
    .chip_select_n(chip_select_n),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n),
    .link(link)
  ); // [RULE17]

  byte_t cmd_r;
  byte_t wdata_r;
  logic [4:0] last_addr_r;
  logic [1:0] byte_cnt_r;
  logic [2:0] rd_pend_r;
  byte_t ctrl_r [`CTRL_REGS];

  wire is_data = (byte_cnt_r == 2'h1) & cmd_r[`CMD_WRITE_BIT];
  wire cmd_take = link.byte_done & ~is_data;
  wire [4:0] rx_addr = link.rx_byte[`CMD_ADDR_MSB:0];
  wire rx_read = ~link.rx_byte[`CMD_WRITE_BIT]; // [RULE24]
  wire [2:0] rx_sr_hit = {rx_addr == `ADDR_SR2, rx_addr == `ADDR_SR1, rx_addr == `ADDR_SR0};
  wire [4:0] wr_addr = cmd_r[`CMD_ADDR_MSB:0];
  wire wr_commit = link.frame_end & link.frame16 & cmd_r[`CMD_WRITE_BIT]; // [RULE25]
  wire wr_wd = wr_commit & (wr_addr == `ADDR_WR);
  wire kick = wr_wd & wdata_r[`WR_KICK_BIT];
  wire kick_zero = wr_wd & ~wdata_r[`WR_KICK_BIT];
  wire [2:0] rd_clear = rd_pend_r & {3{link.frame_end}}; // [RULE26]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_r <= 8'h00;
      wdata_r <= 8'h00;
      last_addr_r <= 5'h00;
      byte_cnt_r <= 2'h0;
      rd_pend_r <= 3'h0;
    end else if (clr_s) begin
      cmd_r <= 8'h00;
      wdata_r <= 8'h00;
      last_addr_r <= 5'h00;
      byte_cnt_r <= 2'h0;
      rd_pend_r <= 3'h0;
    end else if (link.frame_end) begin
      byte_cnt_r <= 2'h0;
      rd_pend_r <= 3'h0;
    end else if (link.byte_done) begin
      byte_cnt_r <= (byte_cnt_r == 2'h3) ? byte_cnt_r : byte_cnt_r + 2'h1;
      if (cmd_take) begin
        cmd_r <= link.rx_byte; // [RULE22]
        last_addr_r <= rx_addr;
        rd_pend_r <= rd_pend_r | (rx_sr_hit & {3{rx_read}});
      end else begin
        wdata_r <= link.rx_byte;
      end
    end
  end

  // Writes land on the fourth system clock after chip select rises
  generate
    for (genvar i = 0; i < `CTRL_REGS; i++) begin : g_ctrl
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          ctrl_r[i] <= `CTRL_RESET;
        end else if (clr_s) begin
          ctrl_r[i] <= `CTRL_RESET; // [RULE14]
        end else if (wr_commit && wr_addr == 5'(i)) begin
          ctrl_r[i] <= wdata_r; // [RULE21]
        end
      end
    end
  endgenerate

  wire [3:0] wd_period = ctrl_r[0][`WR_PERIOD_MSB:`WR_PERIOD_LSB];
  wire motor_on = ctrl_r[3][`CR2_MOTEN_BIT];
  wire sleeping = ctrl_r[3][`CR2_SLEEP_BIT];
  wire gain_quarter = ctrl_r[3][`CR2_SLAG_BIT];

  // ------------------------------------------------------------
  // Timers
  // ------------------------------------------------------------
  logic [1:0] open_done;
  logic pump_ready;
  logic por_done;

  generate
    for (genvar c = 0; c < 2; c++) begin : g_open
      hold_timer #(.LIMIT(OPEN_COIL_CYC)) u_open (
        .clk(clk),
        .reset_n(reset_n),
        .run(full_s[c]),
        .done(open_done[c])
      ); // [RULE6] [RULE27]
    end
  endgenerate

  // Pump keeps running through hard reset, restarts after sleep
  hold_timer #(.LIMIT(PUMP_START_CYC)) u_pump (
    .clk(clk),
    .reset_n(reset_n),
    .run(~sleeping),
    .done(pump_ready)
  ); // [RULE7] [RULE16] [RULE27]

  hold_timer #(.LIMIT(POR_HOLD_CYC)) u_por (
    .clk(clk),
    .reset_n(reset_n),
    .run(1'b1),
    .done(por_done)
  ); // [RULE9]

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  logic tw_r;
  logic tsd_r;
  logic [3:0] ovcx_r;
  logic [3:0] ovcy_r;
  logic [1:0] open_r;
  logic pump_r;
  logic boot_r;
  logic wd_fire;

  // Status flags other than boot are frozen while selected so a read sees a stable value
  wire upd = ~link.selected; // [RULE21]
  wire tw_nxt = warn_s | (tw_r & ~rd_clear[0]); // [RULE2]
  wire tsd_nxt = shut_s | (tsd_r & ~(rd_clear[2] & ~warn_s)); // [RULE3] [RULE4]
  wire [3:0] ovcx_nxt = ovcx_s | (ovcx_r & ~{4{rd_clear[1]}}); // [RULE5]
  wire [3:0] ovcy_nxt = ovcy_s | (ovcy_r & ~{4{rd_clear[2]}}); // [RULE5]
  wire [1:0] open_nxt = open_done | (open_r & ~{2{rd_clear[0]}}); // [RULE6]
  wire pump_nxt = pump_low_s | ~pump_ready | (pump_r & ~rd_clear[0]); // [RULE7]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tw_r <= 1'b0;
      tsd_r <= 1'b0;
      ovcx_r <= 4'h0;
      ovcy_r <= 4'h0;
      open_r <= 2'h0;
      pump_r <= 1'b1;
    end else if (clr_s) begin
      tw_r <= 1'b0;
      tsd_r <= 1'b0;
      ovcx_r <= 4'h0;
      ovcy_r <= 4'h0;
      open_r <= 2'h0;
      pump_r <= 1'b0;
    end else if (upd) begin
      tw_r <= tw_nxt;
      tsd_r <= tsd_nxt;
      ovcx_r <= ovcx_nxt;
      ovcy_r <= ovcy_nxt;
      open_r <= open_nxt;
      pump_r <= pump_nxt;
    end
  end

  // Boot cause survives the host reset so firmware can tell warm from cold
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_r <= 1'b0;
    end else if (clr_s) begin
      boot_r <= 1'b0;
    end else begin
      boot_r <= wd_fire | (boot_r & ~kick_zero); // [RULE11]
    end
  end

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  wd_state_t wd_state_r;
  logic [23:0] wd_cnt_r;

  wire [27:0] wd_limit = 28'(WD_STEP_CYC) * (28'(wd_period) + 28'h1); // [RULE13]
  wire wd_late = ({4'h0, wd_cnt_r} >= wd_limit - 28'h1);
  wire wd_early = kick & (wd_cnt_r < 24'(WD_MIN_CYC));
  assign wd_fire = (wd_state_r == WD_RUN) & ~clr_s & (wd_early | wd_late); // [RULE11]
  wire delay_end = wd_cnt_r == 24'(WD_DELAY_CYC - 1);
  wire pulse_end = wd_cnt_r == 24'(WD_PULSE_CYC - 1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wd_state_r <= WD_OFF;
      wd_cnt_r <= 24'h0;
    end else if (clr_s) begin
      wd_state_r <= WD_OFF;
      wd_cnt_r <= 24'h0;
    end else begin
      unique case (wd_state_r)
        WD_OFF: begin
          wd_cnt_r <= 24'h0;
          if (kick) begin
            wd_state_r <= WD_RUN;
          end
        end
        WD_RUN: begin
          if (wd_fire) begin
            wd_state_r <= WD_DELAY;
            wd_cnt_r <= 24'h0;
          end else begin
            wd_cnt_r <= kick ? 24'h0 : wd_cnt_r + 24'h1; // [RULE10]
          end
        end
        WD_DELAY: begin
          wd_cnt_r <= delay_end ? 24'h0 : wd_cnt_r + 24'h1;
          if (delay_end) begin
            wd_state_r <= WD_PULSE; // [RULE12]
          end
        end
        WD_PULSE: begin
          wd_cnt_r <= pulse_end ? 24'h0 : wd_cnt_r + 24'h1;
          if (pulse_end) begin
            wd_state_r <= WD_OFF;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read data and outputs
  // ------------------------------------------------------------
  logic [6:0] sr0_d;
  logic [6:0] sr1_d;
  logic [6:0] sr2_d;
  byte_t rd_mux;

  always_comb begin
    sr0_d = 7'h00;
    sr0_d[`SR0_TW_BIT] = tw_r;
    sr0_d[`SR0_BOOT_BIT] = boot_r;
    sr0_d[`SR0_PUMP_BIT] = pump_r;
    sr0_d[`SR0_COIL_X_OPEN_FLAG_BIT] = open_r[0];
    sr0_d[`SR0_COIL_Y_OPEN_FLAG_BIT] = open_r[1];
    sr1_d = {3'h0, ovcx_r};
    sr2_d = {3'h0, ovcy_r};
    sr2_d[`SR2_TSD_BIT] = tsd_r;
  end

  assign rd_mux = (last_addr_r == `ADDR_WR) ? ctrl_r[0] :
    (last_addr_r == `ADDR_CR0) ? ctrl_r[1] :
    (last_addr_r == `ADDR_CR1) ? ctrl_r[2] :
    (last_addr_r == `ADDR_CR2) ? ctrl_r[3] :
    (last_addr_r == `ADDR_SR0) ? {^sr0_d, sr0_d} :
    (last_addr_r == `ADDR_SR1) ? {^sr1_d, sr1_d} :
    (last_addr_r == `ADDR_SR2) ? {^sr2_d, sr2_d} : 8'h00;
  assign link.tx_byte = rd_mux; // [RULE20]

  wire any_fault = tw_r | tsd_r | (|ovcx_r) | (|ovcy_r) | (|open_r) | pump_r;
  wire drive_ok = motor_on & ~sleeping & ~tsd_r & ~clr_s; // [RULE3] [RULE15]
  wire x_ok = drive_ok & ~open_r[0] & ~(|ovcx_r); // [RULE5] [RULE6]
  wire y_ok = drive_ok & ~open_r[1] & ~(|ovcy_r); // [RULE5] [RULE6]
  wire host_low = ~por_done | (wd_state_r == WD_PULSE); // [RULE9] [RULE11]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      back_emf_output <= 8'h00;
      x_bridge_enable <= 4'h0;
      y_bridge_enable <= 4'h0;
      step_pulse <= 1'b0;
      step_d_r <= 1'b0;
      fault_output_n <= 1'b1;
      host_reset_output_n <= 1'b0;
      host_reset_oe_n <= 1'b0;
    end else begin
      back_emf_output <= gain_quarter ? {2'h0, coil_voltage_sample[7:2]} :
        {1'h0, coil_voltage_sample[7:1]}; // [RULE1] [RULE23]
      x_bridge_enable <= {4{x_ok}};
      y_bridge_enable <= {4{y_ok}};
      step_d_r <= step_s;
      step_pulse <= step_s & ~step_d_r & ~sleeping & ~clr_s; // [RULE15]
      fault_output_n <= ~any_fault; // [RULE8]
      host_reset_output_n <= 1'b0;
      host_reset_oe_n <= ~host_low;
    end
  end
endmodule : stepper_supervisor_spi_slave

// File: rtl/stepper_supervisor_map.svh
// Register map, field positions and timing figures of the stepper supervisor
`ifndef STEPPER_SUPERVISOR_MAP_SVH
`define STEPPER_SUPERVISOR_MAP_SVH

`define ADDR_WR 5'h00
`define ADDR_CR0 5'h01
`define ADDR_CR1 5'h02
`define ADDR_CR2 5'h03
`define ADDR_SR0 5'h04
`define ADDR_SR1 5'h05
`define ADDR_SR2 5'h06
`define ADDR_SR3 5'h07
`define CTRL_REGS 4
`define CTRL_RESET 8'h00

`define CMD_WRITE_BIT 7
`define CMD_ADDR_MSB 4
`define WR_KICK_BIT 7
`define WR_PERIOD_MSB 6
`define WR_PERIOD_LSB 3
`define CR2_MOTEN_BIT 7
`define CR2_SLEEP_BIT 6
`define CR2_SLAG_BIT 5

`define SR_PARITY_BIT 7
`define SR0_TW_BIT 0
`define SR0_BOOT_BIT 1
`define SR0_PUMP_BIT 2
`define SR0_COIL_X_OPEN_FLAG_BIT 3
`define SR0_COIL_Y_OPEN_FLAG_BIT 4
`define SR2_TSD_BIT 4

`define SPI_LAST_BIT 3'h7
`define SPI_WRITE_BITS 5'h10
`define SPI_BITS_MAX 5'h1F

`define CLK_HZ 20000000
`define OPEN_COIL_MS 200
`define WD_STEP_MS 32
`define WD_MIN_MS 1
`define WD_PULSE_MS 1
`define POR_HOLD_MS 10
`define PUMP_START_MS 5
`define WD_DELAY_NS 500

`endif

// File: rtl/stepper_supervisor_pkg.sv
// Types shared by the stepper supervisor modules
package stepper_supervisor_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {WD_OFF, WD_RUN, WD_DELAY, WD_PULSE} wd_state_t;
endpackage : stepper_supervisor_pkg

// File: rtl/spi_link_if.sv
// Byte-level link between the serial shifter and the supervisor core
`timescale 1ns/1ns
interface spi_link_if;
  import stepper_supervisor_pkg::*;
  byte_t rx_byte;
  logic byte_done;
  logic frame_end;
  logic frame16;
  logic selected;
  byte_t tx_byte;
  modport shifter (output rx_byte, output byte_done, output frame_end, output frame16,
    output selected, input tx_byte);
  modport core (input rx_byte, input byte_done, input frame_end, input frame16,
    input selected, output tx_byte);
endinterface : spi_link_if

// File: rtl/hold_timer.sv
// Counts cycles while run is high and flags reaching the limit
`timescale 1ns/1ns
module hold_timer #(
  parameter int LIMIT = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  output logic done
);
  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LAST = W'(LIMIT);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  assign cnt_nxt = !run ? '0 : (cnt_r == LAST) ? cnt_r : cnt_r + W'(1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
      done <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done <= run && (cnt_r == LAST);
    end
  end
endmodule : hold_timer

// File: rtl/spi_shifter.sv
// Mode 0 serial slave shifter, oversampled on the system clock
`timescale 1ns/1ns
`include "stepper_supervisor_map.svh"
module spi_shifter (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  spi_link_if.shifter link
);
  import stepper_supervisor_pkg::*;
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic sclk_d_r;
  logic sel_d_r;
  logic [2:0] bit_cnt_r;
  logic [4:0] total_r;
  byte_t in_sr_r;
  byte_t out_sr_r;
  logic byte_done_r;
  logic frame_end_r;
  logic frame16_r;

  wire sclk_s = s2_r[2];
  wire sel_s = ~s2_r[1];
  wire din_s = s2_r[0];
  wire rise = sel_s & sclk_s & ~sclk_d_r; // [RULE18]
  wire fall = sel_s & ~sclk_s & sclk_d_r; // [RULE18]
  wire byte_end = rise & (bit_cnt_r == `SPI_LAST_BIT);
  wire [4:0] total_nxt = (total_r == `SPI_BITS_MAX) ? total_r : total_r + 5'h01;

  assign link.rx_byte = in_sr_r;
  assign link.byte_done = byte_done_r;
  assign link.frame_end = frame_end_r;
  assign link.frame16 = frame16_r;
  assign link.selected = sel_s;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= 3'h2;
      s2_r <= 3'h2;
      sclk_d_r <= 1'b0;
      sel_d_r <= 1'b0;
    end else begin
      s1_r <= {sclk, chip_select_n, serial_in};
      s2_r <= s1_r;
      sclk_d_r <= sclk_s;
      sel_d_r <= sel_s;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_r <= 3'h0;
      total_r <= 5'h00;
      in_sr_r <= 8'h00;
    end else if (!sel_s) begin
      bit_cnt_r <= 3'h0;
      total_r <= 5'h00;
    end else if (rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      total_r <= total_nxt;
      in_sr_r <= {in_sr_r[6:0], din_s}; // [RULE22]
    end
  end

  // Stale first byte is expected: reload only after a full byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_sr_r <= 8'hFF;
    end else if (fall) begin
      out_sr_r <= (bit_cnt_r == 3'h0) ? link.tx_byte : {out_sr_r[6:0], 1'b1}; // [RULE20]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_done_r <= 1'b0;
      frame_end_r <= 1'b0;
      frame16_r <= 1'b0;
      serial_out <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end else begin
      byte_done_r <= byte_end;
      frame_end_r <= sel_d_r & ~sel_s;
      frame16_r <= sel_d_r & ~sel_s & (total_r == `SPI_WRITE_BITS);
      serial_out <= 1'b0;
      serial_out_oe_n <= ~(sel_s & ~out_sr_r[7]); // [RULE19]
    end
  end
endmodule : spi_shifter

// File: verif/stepper_supervisor_spi_slave_monitor.sv
// Port-level assertions for the stepper supervisor
`timescale 1ns/1ns
module stepper_supervisor_spi_slave_monitor #(
  parameter int POR_HOLD_CYC = 20,
  parameter int PUMP_START_CYC = 20
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chip_select_n,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic temp_warning_in,
  input wire logic temp_shutdown_in,
  input wire logic [3:0] x_overcurrent_in,
  input wire logic hard_reset_input,
  input wire stepper_supervisor_pkg::byte_t coil_voltage_sample,
  input wire stepper_supervisor_pkg::byte_t back_emf_output,
  input wire logic [3:0] x_bridge_enable,
  input wire logic [3:0] y_bridge_enable,
  input wire logic step_pulse,
  input wire logic fault_output_n,
  input wire logic host_reset_output_n,
  input wire logic host_reset_oe_n
);
  import stepper_supervisor_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Cycles since power-on release
  // ----------------------------------------
  logic [15:0] por_cnt_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) por_cnt_r <= 16'h0000;
    else if (por_cnt_r != 16'hFFFF) por_cnt_r <= por_cnt_r + 16'h0001;
  end
  chk_emf_scale: assert property ($stable(coil_voltage_sample) [*6] |->
    back_emf_output inside {coil_voltage_sample >> 1, coil_voltage_sample >> 2})
    else $error("back-emf output not a half or quarter of the sample");
  chk_warn_fault: assert property ((temp_warning_in && !hard_reset_input) [*8]
    |-> !fault_output_n) else $error("fault output idle during thermal warning");
  chk_shutdown_off: assert property (temp_shutdown_in [*5] |->
    (x_bridge_enable | y_bridge_enable) == 4'h0) else $error("bridges on during overheat");
  chk_ovc_off: assert property ((|x_overcurrent_in) [*5] |-> x_bridge_enable == 4'h0)
    else $error("x bridge on during over-current");
  chk_bridge_whole: assert property ({x_bridge_enable, y_bridge_enable} inside
    {8'h00, 8'h0F, 8'hF0, 8'hFF}) else $error("bridge enables split");
  chk_drain_only: assert property (serial_out == 1'b0 && host_reset_output_n == 1'b0)
    else $error("open-drain pin driven high");
  chk_cs_release: assert property (chip_select_n [*6] |-> serial_out_oe_n)
    else $error("serial output held while unselected");
  chk_step_single: assert property (step_pulse |=> !step_pulse)
    else $error("step pulse longer than one cycle");
  chk_por_hold: assert property (por_cnt_r < POR_HOLD_CYC |-> !host_reset_oe_n)
    else $error("host reset released too early");
  chk_pump_start: assert property (por_cnt_r >= 3 && por_cnt_r < PUMP_START_CYC
    |-> !fault_output_n) else $error("pump fault not flagged at start-up");
  cover property (!fault_output_n ##1 fault_output_n);
  cover property (por_cnt_r > POR_HOLD_CYC && $fell(host_reset_oe_n));
  cover property (step_pulse);
endmodule : stepper_supervisor_spi_slave_monitor

bind stepper_supervisor_spi_slave stepper_supervisor_spi_slave_monitor #(
  .POR_HOLD_CYC(POR_HOLD_CYC), .PUMP_START_CYC(PUMP_START_CYC)) mon (.clk, .reset_n,
  .chip_select_n, .serial_out, .serial_out_oe_n, .temp_warning_in, .temp_shutdown_in,
  .x_overcurrent_in, .hard_reset_input, .coil_voltage_sample, .back_emf_output,
  .x_bridge_enable, .y_bridge_enable, .step_pulse, .fault_output_n, .host_reset_output_n,
  .host_reset_oe_n);

// File: verif/spi_master_model.sv
// Mode 0 serial master standing in for the host controller
`timescale 1ns/1ns
module spi_master_model (
  output logic sclk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  wire logic line_in;
  // Pull-up sets the level whenever the slave lets go
  assign line_in = serial_out_oe_n ? 1'b1 : serial_out;
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // Only this model starts frames; clock rests low outside them
  task automatic frame(input int nbits, input logic [15:0] d, output logic [15:0] q);
    int i;
    chip_select_n = 1'b0;
    q = 16'h0000;
    for (i = 0; i < nbits; i++) begin
      serial_in = d[15 - i];
      #200 sclk = 1'b1;
      q = {q[14:0], line_in};
      #200 sclk = 1'b0;
    end
    #200 chip_select_n = 1'b1;
    // Released data line must not keep its last bit
    serial_in = ~serial_in;
    #400;
  endtask : frame
endmodule : spi_master_model

// File: verif/test_stepper_supervisor_spi_slave.sv
// Self-checking bench for the stepper supervisor serial slave
`timescale 1ns/1ns
`include "stepper_supervisor_map.svh"
module test_stepper_supervisor_spi_slave;
  import stepper_supervisor_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic sclk, chip_select_n, serial_in, serial_out, serial_out_oe_n;
  logic temp_warning_in = 1'b0, temp_shutdown_in = 1'b0;
  logic [3:0] x_overcurrent_in = 4'h0, y_overcurrent_in = 4'h0;
  logic [1:0] full_duty_in = 2'h0;
  logic pump_low_in = 1'b0, hard_reset_input = 1'b0, step_advance_input = 1'b0;
  byte_t coil_voltage_sample = 8'h00;
  byte_t back_emf_output;
  logic [3:0] x_bridge_enable, y_bridge_enable;
  logic step_pulse, fault_output_n, host_reset_output_n, host_reset_oe_n;
  int err_total = 0, cmp_count = 0, steps = 0, cycles = 0;
  stepper_supervisor_spi_slave #(.OPEN_COIL_CYC(50), .WD_STEP_CYC(400), .WD_MIN_CYC(200),
    .POR_HOLD_CYC(20), .PUMP_START_CYC(20)) DUT (.clk, .reset_n, .sclk,
    .chip_select_n, .serial_in, .serial_out, .serial_out_oe_n, .temp_warning_in,
    .temp_shutdown_in, .x_overcurrent_in, .y_overcurrent_in, .full_duty_in, .pump_low_in,
    .hard_reset_input, .step_advance_input, .coil_voltage_sample, .back_emf_output,
    .x_bridge_enable, .y_bridge_enable, .step_pulse, .fault_output_n, .host_reset_output_n,
    .host_reset_oe_n);
  spi_master_model mst (.sclk, .chip_select_n, .serial_in, .serial_out, .serial_out_oe_n);
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (step_pulse === 1'b1) steps++;
    cycles++;
    // Two full-length reset pulses make the run about 46000 cycles
    if (cycles == 60000) begin
      err_total++;
      summarize();
    end
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc
  task automatic rd(input byte_t a, input byte_t exp);
    logic [15:0] q;
    mst.frame(16, {a, 8'h00}, q);
    check(q[7:0], exp);
  endtask : rd
  task automatic wr(input byte_t a, input byte_t d);
    logic [15:0] q;
    mst.frame(16, {8'h80 | a, d}, q);
  endtask : wr
  task automatic wd_fire(input int lo, input int hi);
    int n;
    n = 0;
    while (host_reset_oe_n === 1'b1 && n < hi) begin
      cyc(1);
      n++;
    end
    check(n >= lo && n < hi, 1'b1);
    n = 0;
    while (host_reset_oe_n === 1'b0 && n < 30000) begin
      cyc(1);
      n++;
    end
    check(n, `WD_PULSE_MS * (`CLK_HZ / 1000));
  endtask : wd_fire
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    logic [15:0] q;
    cyc(4);
    reset_n = 1'b1;
    cyc(6);
    check(host_reset_oe_n, 1'b0);
    check(fault_output_n, 1'b0);
    cyc(30);
    check(host_reset_oe_n, 1'b1);
    rd(8'h04, 8'h84);
    cyc(4);
    check(fault_output_n, 1'b1);
    rd(8'h04, 8'h00);
    wr(8'h03, 8'h80);
    rd(8'h03, 8'h80);
    check(x_bridge_enable, 4'hF);
    mst.frame(15, {8'h83, 8'hA0}, q);
    rd(8'h03, 8'h80);
    coil_voltage_sample = 8'hC8;
    cyc(8);
    check(back_emf_output, 8'h64);
    wr(8'h03, 8'hA0);
    cyc(8);
    check(back_emf_output, 8'h32);
    hard_reset_input = 1'b1;
    cyc(5);
    hard_reset_input = 1'b0;
    cyc(5);
    rd(8'h03, 8'h00);
    wr(8'h03, 8'h80);
    temp_warning_in = 1'b1;
    cyc(8);
    check(fault_output_n, 1'b0);
    temp_shutdown_in = 1'b1;
    cyc(6);
    check({x_bridge_enable, y_bridge_enable}, 8'h00);
    temp_shutdown_in = 1'b0;
    rd(8'h04, 8'h81);
    rd(8'h06, 8'h90);
    rd(8'h06, 8'h90);
    temp_warning_in = 1'b0;
    cyc(6);
    rd(8'h06, 8'h90);
    rd(8'h06, 8'h00);
    rd(8'h04, 8'h81);
    rd(8'h04, 8'h00);
    x_overcurrent_in = 4'h2;
    y_overcurrent_in = 4'h8;
    cyc(6);
    x_overcurrent_in = 4'h0;
    y_overcurrent_in = 4'h0;
    cyc(8);
    check({x_bridge_enable, y_bridge_enable}, 8'h00);
    rd(8'h05, 8'h82);
    rd(8'h06, 8'h88);
    cyc(4);
    check({x_bridge_enable, y_bridge_enable}, 8'hFF);
    full_duty_in = 2'h1;
    cyc(70);
    check({x_bridge_enable, y_bridge_enable}, 8'h0F);
    full_duty_in = 2'h0;
    rd(8'h04, 8'h88);
    step_advance_input = 1'b1;
    cyc(4);
    step_advance_input = 1'b0;
    cyc(4);
    check(steps, 1);
    wr(8'h03, 8'hC0);
    step_advance_input = 1'b1;
    cyc(4);
    step_advance_input = 1'b0;
    cyc(4);
    check(steps, 1);
    check(x_bridge_enable, 4'h0);
    rd(8'h03, 8'hC0);
    wr(8'h03, 8'h80);
    cyc(30);
    rd(8'h04, 8'h84);
    check(x_bridge_enable, 4'hF);
    pump_low_in = 1'b1;
    cyc(6);
    check(fault_output_n, 1'b0);
    pump_low_in = 1'b0;
    rd(8'h04, 8'h84);
    wr(8'h00, 8'h88);
    cyc(300);
    wr(8'h00, 8'h88);
    wd_fire(750, 870);
    wr(8'h00, 8'h88);
    wr(8'h00, 8'h88);
    wd_fire(3, 40);
    rd(8'h04, 8'h82);
    rd(8'h04, 8'h82);
    wr(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    summarize();
  end
endmodule : test_stepper_supervisor_spi_slave
